// ==== sft_host.sv ====
`timescale 1ns/10ps
module sft_host (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Six clocks a phase keeps SCL well above the four-clock floor
  task automatic hold;
    repeat (6) @(negedge ref_clk_i);
  endtask
  // SDA moves two clocks after SCL falls so no edge looks like start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o = ~b;
    hold;
    scl_o = 1'b1;
    hold;
    r = sda_i;
    scl_o = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  task automatic start;
    sda_pull_o = 1'b0;
    hold;
    scl_o = 1'b1;
    hold;
    sda_pull_o = 1'b1;
    hold;
    scl_o = 1'b0;
  endtask
  task automatic stop;
    sda_pull_o = 1'b1;
    hold;
    scl_o = 1'b1;
    hold;
    sda_pull_o = 1'b0;
    hold;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, a);
    ack = ~a;
  endtask
  task automatic addr(input logic [15:0] a, output logic ack);
    logic [7:0] q;
    logic [2:0] k;
    start;
    xfer({sft_pkg::SFT_DEV_ADDR, 1'b0}, 1'b1, q, k[2]);
    xfer(a[15:8], 1'b1, q, k[1]);
    xfer(a[7:0], 1'b1, q, k[0]);
    ack = &k;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic       k;
    addr(a, k);
    xfer(d, 1'b1, q, ack);
    ack = ack & k;
    stop;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    logic k;
    addr(a, k);
    start;
    xfer({sft_pkg::SFT_DEV_ADDR, 1'b1}, 1'b1, d, k);
    xfer(8'hff, 1'b1, d, k);
    stop;
  endtask
endmodule

// ==== sft_pkg.sv ====
package sft_pkg;

  localparam int SFT_NREG       = 50;
  localparam int SFT_FIFO_WIDTH = 24;
  localparam int SFT_FIFO_DEPTH = 8;

  // Two-wire slave address, write form shifted right by one
  localparam logic [6:0]  SFT_DEV_ADDR      = 7'h31;
  localparam logic [3:0]  SFT_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0]  SFT_LAST_PHASE    = 2'h3;

  localparam logic [13:0] SFT_FIXED_LINES = 14'h0018;
  localparam logic [13:0] SFT_MIN_BLANK   = 14'h0000;
  localparam logic [13:0] SFT_EXPO_MARGIN = 14'h0008;

  localparam logic [1:0]  SFT_LANE_CODE_1 = 2'h0;
  localparam logic [1:0]  SFT_LANE_CODE_2 = 2'h1;
  localparam logic [1:0]  SFT_LANE_CODE_4 = 2'h2;
  localparam logic [2:0]  SFT_LANES_1     = 3'h1;
  localparam logic [2:0]  SFT_LANES_2     = 3'h2;
  localparam logic [2:0]  SFT_LANES_4     = 3'h4;

  // Register indices into the address, reset and mask tables
  localparam int SFT_I_TEST = 0, SFT_I_OFFS = 1, SFT_I_OWW_HI = 2, SFT_I_OWW_LO = 3;
  localparam int SFT_I_OWH_HI = 4, SFT_I_OWH_LO = 5, SFT_I_SER = 11, SFT_I_WCNT_LO = 12;
  localparam int SFT_I_WCNT_HI = 13, SFT_I_PKT = 14, SFT_I_DEPTH = 15, SFT_I_LANES = 16;
  localparam int SFT_I_PHY = 17, SFT_I_EX2_HI = 31, SFT_I_EX2_LO = 32, SFT_I_SH_HI = 33;
  localparam int SFT_I_SH_LO = 34, SFT_I_HDR = 35, SFT_I_FR_HI = 36, SFT_I_FR_LO = 37;
  localparam int SFT_I_LP_HI = 38, SFT_I_LP_LO = 39, SFT_I_AH_HI = 44, SFT_I_AH_LO = 45;
  localparam int SFT_I_LCFG1 = 48, SFT_I_LCFG2 = 49;

  // Field positions
  localparam int SFT_SER_LANE_EN = 3, SFT_SER_ULP = 2, SFT_SER_LSYNC = 1, SFT_SER_OUT = 0;
  localparam int SFT_PHY_HOLD = 7, SFT_PHY_GATE = 6, SFT_PHY_OPEN = 5;
  localparam int SFT_HDR_EN = 0, SFT_HDR_ALL = 6, SFT_TEST_EN = 2, SFT_LCFG1_EN = 6;

  localparam logic [15:0] SFT_ADDR [SFT_NREG] = '{
    16'h008c, 16'h008e, 16'h0094, 16'h0095, 16'h0096, 16'h0097, 16'h0098, 16'h0099,
    16'h009a, 16'h009b, 16'h009c, 16'h0100, 16'h010d, 16'h010e, 16'h0111, 16'h0112,
    16'h0114, 16'h0115, 16'h0120, 16'h0121, 16'h0122, 16'h0123, 16'h0124, 16'h0125,
    16'h0126, 16'h0127, 16'h0128, 16'h0129, 16'h012a, 16'h012b, 16'h012c, 16'h0200,
    16'h0201, 16'h0202, 16'h0203, 16'h0222, 16'h0340, 16'h0341, 16'h0342, 16'h0343,
    16'h0346, 16'h0347, 16'h0348, 16'h0349, 16'h034a, 16'h034b, 16'h070c, 16'h070d,
    16'h0180, 16'h0181};

  localparam logic [7:0] SFT_RST [SFT_NREG] = '{
    8'h10, 8'h05, 8'h0b, 8'h90, 8'h06, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h20, 8'h20, 8'h0d, 8'h2b, 8'h01, 8'h03, 8'h10, 8'h80, 8'h10,
    8'h05, 8'h20, 8'h02, 8'h20, 8'h08, 8'h10, 8'ha0, 8'h06, 8'h0a, 8'h08,
    8'h10, 8'h00, 8'h04, 8'h00, 8'h10, 8'h00, 8'h07, 8'h0d, 8'h07, 8'h80,
    8'h00, 8'h02, 8'h09, 8'h0c, 8'h05, 8'h18, 8'h00, 8'h00, 8'h06, 8'h00};

  localparam logic [7:0] SFT_MASK [SFT_NREG] = '{
    8'hff, 8'h0f, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h7f, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'h41, 8'h3f, 8'hff, 8'hff, 8'hff,
    8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h07, 8'h7f, 8'hff};

  typedef enum logic [4:0] {
    SFT_ST_IDLE = 5'h01,
    SFT_ST_RX   = 5'h02,
    SFT_ST_ACK  = 5'h04,
    SFT_ST_TX   = 5'h08,
    SFT_ST_RACK = 5'h10
  } sft_state_t;

endpackage

// ==== sft_regs.sv ====
// Functional notes
// [R01] Actual frame length from height, blank, shutter
// [R02] Minimum frame equals height plus 24 plus blank
// [R03] Short shutter uses minimum frame length
// [R04] Host programs shutter plus 8 when longer
// [R05] Frame blank is frame length minus height
// [R06] Line blank derived from line length
// [R07] Host leaves internal line length unchanged
// [R08] Serial control lane, low power, sync, enable
// [R09] Lane code 00/01/10 means 1/2/4 lanes
// [R10] Packet header: channel and data type
// [R11] Phy mode gate, open, bit order, clock
// [R12] Phy bit 7 holds timing on divide
// [R13] Dual exposure enable and all frames out
// [R14] Flip and mirror offsets, default 2; code resets both to 1
// [R15] Test bit replaces pixels with pattern
// [R16] Per-lane enables and one-step delays
// [R17] Lane config: enable, disable, differential
// [R18] Host raises frame length before long exposure
// [R19] Timing settings apply at frame boundary
// [R20] Readback, zero undefined bits, reset defaults
`timescale 1ns/10ps

module sft_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_r != FULL);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

module sft_regs (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        frame_start_i,
  input  wire logic        pixel_valid_i,
  input  wire logic [9:0]  pixel_i,
  output logic             pixel_valid_o,
  output logic      [9:0]  pixel_o,
  output logic      [13:0] frame_length_o,
  output logic      [13:0] vertical_blank_lines_o,
  output logic      [13:0] frame_blank_o,
  output logic      [15:0] line_blank_o,
  output logic      [15:0] line_period_o,
  output logic      [13:0] exposure_o,
  output logic      [13:0] second_exposure_time_o,
  output logic             lane_enable_o,
  output logic             ultra_low_power_enable_o,
  output logic             line_sync_mode_o,
  output logic             serial_out_enable_o,
  output logic      [2:0]  lanes_active_o,
  output logic      [1:0]  virtual_channel_field_o,
  output logic      [5:0]  data_type_o,
  output logic             timing_hold_on_divide_o,
  output logic             data_lane_gate_o,
  output logic             all_lanes_open_o,
  output logic      [2:0]  bit_order_switch_o,
  output logic      [1:0]  clock_lane_mode_o,
  output logic             dual_exposure_en_o,
  output logic             all_exposure_out_o,
  output logic      [1:0]  flip_row_offset_o,
  output logic      [1:0]  mirror_col_offset_o,
  output logic      [3:0]  lane_enable_mask_o,
  output logic      [3:0]  lane_one_step_delay_o,
  output logic             serial_if_enable_o,
  output logic      [1:0]  disable_setting_o,
  output logic      [3:0]  diff_setting_o
);
  localparam int NR = sft_pkg::SFT_NREG;

  logic [7:0]  reg_r [NR];
  logic [7:0]  app_r [NR];
  logic        scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic        scl_rise, scl_fall, start_det, stop_det;
  sft_pkg::sft_state_t state_r;
  logic [3:0]  bitcnt_r;
  logic [1:0]  phase_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic [15:0] addr_r;
  logic        rd_mode_r, nack_r, oe_r;
  logic [7:0]  rdata;
  logic        byte_done, wr_valid, wr_ready;
  logic        rf_valid, rf_ready, rf_fire;
  logic [23:0] rf_data;
  logic [11:0] win_h, out_h, out_w;
  logic [13:0] frame_prog, base_lines, vert_blank, min_frame, shut, actual;
  logic [15:0] line_len;
  logic [9:0]  test_pix_r;
  logic        past_ok_r;

  // Pins come from the host's clock world, two stages before use
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  assign scl_rise  = scl_s2 & ~scl_d;
  assign scl_fall  = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign byte_done = (state_r == sft_pkg::SFT_ST_RX) && scl_fall
                     && (bitcnt_r == sft_pkg::SFT_BITS_PER_BYTE);
  assign wr_valid  = byte_done && (phase_r == sft_pkg::SFT_LAST_PHASE);
  assign sda_o     = 1'b0;
  assign sda_oe_o  = oe_r;

  // Two-byte address then data; address steps after every byte
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= sft_pkg::SFT_ST_IDLE;
      bitcnt_r  <= '0;
      phase_r   <= '0;
      shift_r   <= '0;
      tx_r      <= '0;
      addr_r    <= '0;
      rd_mode_r <= 1'b0;
      nack_r    <= 1'b0;
      oe_r      <= 1'b0;
    end else if (start_det) begin
      state_r  <= sft_pkg::SFT_ST_RX;
      bitcnt_r <= '0;
      phase_r  <= '0;
      oe_r     <= 1'b0;
    end else if (stop_det) begin
      state_r <= sft_pkg::SFT_ST_IDLE;
      oe_r    <= 1'b0;
    end else begin
      case (state_r)
        sft_pkg::SFT_ST_RX: begin
          if (scl_rise) begin
            shift_r  <= {shift_r[6:0], sda_s2};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (byte_done) begin
            bitcnt_r <= '0;
            state_r  <= sft_pkg::SFT_ST_ACK;
            oe_r     <= 1'b1;
            case (phase_r)
              2'h0: begin
                rd_mode_r <= shift_r[0];
                if (shift_r[7:1] != sft_pkg::SFT_DEV_ADDR) begin
                  state_r <= sft_pkg::SFT_ST_IDLE;
                  oe_r    <= 1'b0;
                end
              end
              2'h1: addr_r[15:8] <= shift_r;
              2'h2: addr_r[7:0] <= shift_r;
              default: begin
                // A full queue refuses the byte with a NACK
                if (wr_ready) begin
                  addr_r <= addr_r + 16'h0001;
                end else begin
                  state_r <= sft_pkg::SFT_ST_IDLE;
                  oe_r    <= 1'b0;
                end
              end
            endcase
          end
        end
        sft_pkg::SFT_ST_ACK: begin
          if (scl_fall) begin
            if (rd_mode_r) begin
              state_r  <= sft_pkg::SFT_ST_TX;
              tx_r     <= rdata;
              oe_r     <= ~rdata[7];
              bitcnt_r <= 4'h1;
              addr_r   <= addr_r + 16'h0001;
            end else begin
              state_r <= sft_pkg::SFT_ST_RX;
              oe_r    <= 1'b0;
              if (phase_r != sft_pkg::SFT_LAST_PHASE) phase_r <= phase_r + 2'h1;
            end
          end
        end
        sft_pkg::SFT_ST_TX: begin
          if (scl_fall) begin
            if (bitcnt_r == sft_pkg::SFT_BITS_PER_BYTE) begin
              state_r <= sft_pkg::SFT_ST_RACK;
              oe_r    <= 1'b0;
            end else begin
              oe_r     <= ~tx_r[6];
              tx_r     <= {tx_r[6:0], 1'b0};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        sft_pkg::SFT_ST_RACK: begin
          if (scl_rise) begin
            nack_r <= sda_s2;
          end else if (scl_fall) begin
            if (nack_r) begin
              state_r <= sft_pkg::SFT_ST_IDLE;
            end else begin
              state_r  <= sft_pkg::SFT_ST_TX;
              tx_r     <= rdata;
              oe_r     <= ~rdata[7];
              bitcnt_r <= 4'h1;
              addr_r   <= addr_r + 16'h0001;
            end
          end
        end
        default: state_r <= sft_pkg::SFT_ST_IDLE;
      endcase
    end
  end

  sft_fifo #(
    .WIDTH (sft_pkg::SFT_FIFO_WIDTH),
    .DEPTH (sft_pkg::SFT_FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (wr_valid),
    .in_ready_o  (wr_ready),
    .in_data_i   ({addr_r, shift_r}),
    .out_valid_o (rf_valid),
    .out_ready_i (rf_ready),
    .out_data_o  (rf_data)
  );

  // Writes wait out the commit cycle so a snapshot never sees half a write
  assign rf_ready = ~frame_start_i;
  assign rf_fire  = rf_valid & rf_ready;

  for (genvar i = 0; i < NR; i++) begin : g_reg
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        reg_r[i] <= sft_pkg::SFT_RST[i]; // R20
        app_r[i] <= sft_pkg::SFT_RST[i];
      end else begin
        if (rf_fire && rf_data[23:8] == sft_pkg::SFT_ADDR[i]) begin
          reg_r[i] <= rf_data[7:0] & sft_pkg::SFT_MASK[i]; // R20
        end
        if (frame_start_i) begin
          app_r[i] <= reg_r[i]; // R19
        end
      end
    end
  end

  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < NR; i++) begin
      if (addr_r == sft_pkg::SFT_ADDR[i]) rdata = reg_r[i]; // R20
    end
  end

  always_comb begin
    win_h      = {app_r[sft_pkg::SFT_I_AH_HI][3:0], app_r[sft_pkg::SFT_I_AH_LO]};
    out_h      = {app_r[sft_pkg::SFT_I_OWH_HI][3:0], app_r[sft_pkg::SFT_I_OWH_LO]};
    out_w      = {app_r[sft_pkg::SFT_I_OWW_HI][3:0], app_r[sft_pkg::SFT_I_OWW_LO]};
    frame_prog = {app_r[sft_pkg::SFT_I_FR_HI][5:0], app_r[sft_pkg::SFT_I_FR_LO]}; // R01
    shut       = {app_r[sft_pkg::SFT_I_SH_HI][5:0], app_r[sft_pkg::SFT_I_SH_LO]};
    line_len   = {app_r[sft_pkg::SFT_I_LP_HI], app_r[sft_pkg::SFT_I_LP_LO]}; // R07
    base_lines = {2'b00, win_h} + sft_pkg::SFT_FIXED_LINES; // R02
    // Programmed frame length beyond height plus the fixed lines is the vertical blank
    vert_blank = (frame_prog > base_lines) ? (frame_prog - base_lines) : sft_pkg::SFT_MIN_BLANK;
    min_frame  = base_lines + vert_blank; // R02
    // A long shutter stretches the frame to the shutter plus the recommended margin
    actual     = (shut > min_frame) ? (shut + sft_pkg::SFT_EXPO_MARGIN) : min_frame; // R03
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_length_o         <= '0;
      vertical_blank_lines_o <= '0;
      frame_blank_o          <= '0;
      line_blank_o           <= '0;
      line_period_o          <= '0;
      exposure_o             <= '0;
      second_exposure_time_o <= '0;
      past_ok_r              <= 1'b0;
    end else begin
      frame_length_o         <= actual; // R01
      vertical_blank_lines_o <= vert_blank; // R02
      frame_blank_o          <= (actual > {2'b00, out_h}) ? (actual - {2'b00, out_h}) : '0; // R05
      line_blank_o           <= (line_len > {4'h0, out_w}) ? (line_len - {4'h0, out_w}) : '0; // R06
      line_period_o          <= line_len;
      exposure_o             <= shut;
      second_exposure_time_o <= {app_r[sft_pkg::SFT_I_EX2_HI][5:0], app_r[sft_pkg::SFT_I_EX2_LO]};
      past_ok_r              <= 1'b1;
    end
  end

  always_comb begin
    lane_enable_o            = reg_r[sft_pkg::SFT_I_SER][sft_pkg::SFT_SER_LANE_EN]; // R08
    ultra_low_power_enable_o = reg_r[sft_pkg::SFT_I_SER][sft_pkg::SFT_SER_ULP];
    line_sync_mode_o         = reg_r[sft_pkg::SFT_I_SER][sft_pkg::SFT_SER_LSYNC];
    serial_out_enable_o      = reg_r[sft_pkg::SFT_I_SER][sft_pkg::SFT_SER_OUT];
    virtual_channel_field_o  = reg_r[sft_pkg::SFT_I_PKT][7:6]; // R10
    data_type_o              = reg_r[sft_pkg::SFT_I_PKT][5:0];
    timing_hold_on_divide_o  = reg_r[sft_pkg::SFT_I_PHY][sft_pkg::SFT_PHY_HOLD]; // R12
    data_lane_gate_o         = reg_r[sft_pkg::SFT_I_PHY][sft_pkg::SFT_PHY_GATE]; // R11
    all_lanes_open_o         = reg_r[sft_pkg::SFT_I_PHY][sft_pkg::SFT_PHY_OPEN];
    bit_order_switch_o       = reg_r[sft_pkg::SFT_I_PHY][4:2];
    clock_lane_mode_o        = reg_r[sft_pkg::SFT_I_PHY][1:0];
    dual_exposure_en_o       = reg_r[sft_pkg::SFT_I_HDR][sft_pkg::SFT_HDR_EN]; // R13
    all_exposure_out_o       = reg_r[sft_pkg::SFT_I_HDR][sft_pkg::SFT_HDR_ALL];
    flip_row_offset_o        = reg_r[sft_pkg::SFT_I_OFFS][3:2]; // R14
    mirror_col_offset_o      = reg_r[sft_pkg::SFT_I_OFFS][1:0];
    lane_enable_mask_o       = reg_r[sft_pkg::SFT_I_LCFG2][7:4]; // R16
    lane_one_step_delay_o    = reg_r[sft_pkg::SFT_I_LCFG2][3:0];
    serial_if_enable_o       = reg_r[sft_pkg::SFT_I_LCFG1][sft_pkg::SFT_LCFG1_EN]; // R17
    disable_setting_o        = reg_r[sft_pkg::SFT_I_LCFG1][5:4];
    diff_setting_o           = reg_r[sft_pkg::SFT_I_LCFG1][3:0];
  end

  // Unused code 11 falls back to four lanes
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lanes_active_o <= sft_pkg::SFT_LANES_4;
    end else begin
      case (reg_r[sft_pkg::SFT_I_LANES][1:0])
        sft_pkg::SFT_LANE_CODE_1: lanes_active_o <= sft_pkg::SFT_LANES_1; // R09
        sft_pkg::SFT_LANE_CODE_2: lanes_active_o <= sft_pkg::SFT_LANES_2; // R09
        default: lanes_active_o <= sft_pkg::SFT_LANES_4; // R09
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      test_pix_r    <= '0;
      pixel_o       <= '0;
      pixel_valid_o <= 1'b0;
    end else begin
      pixel_valid_o <= pixel_valid_i;
      if (pixel_valid_i) begin
        test_pix_r <= test_pix_r + 10'h001;
        pixel_o    <= reg_r[sft_pkg::SFT_I_TEST][sft_pkg::SFT_TEST_EN] ? test_pix_r : pixel_i; // R15
      end
    end
  end

  sequence byte_nack_s;
    wr_valid && !wr_ready;
  endsequence

  short_frame_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R03
    (shut <= min_frame) |=> (frame_length_o == $past(min_frame)))
    else $error("short shutter did not give minimum frame");
  long_frame_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R01
    (shut > min_frame) |=> (frame_length_o == $past(shut) + sft_pkg::SFT_EXPO_MARGIN))
    else $error("long shutter frame length wrong");
  min_frame_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R02
    past_ok_r |-> (frame_length_o >= 14'($past(win_h)) + sft_pkg::SFT_FIXED_LINES))
    else $error("frame shorter than height plus fixed lines");
  frame_blank_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R05
    (past_ok_r && $past(actual) > 14'($past(out_h)))
    |-> (frame_blank_o == frame_length_o - 14'($past(out_h))))
    else $error("frame blank mismatch");
  commit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R19
    frame_start_i |=> (app_r[sft_pkg::SFT_I_SH_LO] == $past(reg_r[sft_pkg::SFT_I_SH_LO])))
    else $error("shutter not committed at frame start");
  hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R19
    !frame_start_i |=> $stable(app_r[sft_pkg::SFT_I_FR_LO]) && $stable(app_r[sft_pkg::SFT_I_FR_HI]))
    else $error("frame length changed between frames");
  readback_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R20
    (rf_fire && rf_data[23:8] == 16'h0340)
    |=> (reg_r[sft_pkg::SFT_I_FR_HI] == ($past(rf_data[7:0]) & 8'h3f)))
    else $error("frame length high byte readback wrong");
  lane_decode_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R09
    (reg_r[sft_pkg::SFT_I_LANES][1:0] == 2'h1) |=> (lanes_active_o == 3'h2))
    else $error("two-lane code decoded wrong");
  nack_full_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R20
    byte_nack_s |=> (state_r == sft_pkg::SFT_ST_IDLE) && !sda_oe_o)
    else $error("byte acknowledged while queue full");
  test_pix_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R15
    (pixel_valid_i && reg_r[sft_pkg::SFT_I_TEST][2]) |=> (pixel_o == $past(test_pix_r)))
    else $error("test pattern not inserted");
endmodule

// ==== sft_regs_tb.sv ====
`timescale 1ns/10ps
module sft_regs_tb;
  logic        ref_clk_i = 1'b0, resetn_i = 1'b0, frame_start_i = 1'b0, pixel_valid_i = 1'b0;
  logic [9:0]  pixel_i = 10'h3ff, pixel_o, p0, p1;
  logic        scl_i, host_pull, sda_o, sda_oe_o, pixel_valid_o, k;
  logic [13:0] frame_length_o, vertical_blank_lines_o, frame_blank_o;
  logic [13:0] exposure_o, second_exposure_time_o;
  logic [15:0] line_blank_o, line_period_o;
  logic [7:0]  q;
  logic [5:0]  data_type_o;
  logic [3:0]  lane_enable_mask_o, lane_one_step_delay_o, diff_setting_o;
  logic [2:0]  lanes_active_o, bit_order_switch_o;
  logic [1:0]  virtual_channel_field_o, clock_lane_mode_o, flip_row_offset_o;
  logic [1:0]  mirror_col_offset_o, disable_setting_o;
  logic        lane_enable_o, ultra_low_power_enable_o, line_sync_mode_o, serial_out_enable_o;
  logic        timing_hold_on_divide_o, data_lane_gate_o, all_lanes_open_o, serial_if_enable_o;
  logic        dual_exposure_en_o, all_exposure_out_o;
  int          bad_count = 0, checks = 0;
  // Open-drain wire with pull-up
  wire         sda_i = (sda_oe_o ? sda_o : 1'b1) & ~host_pull;

  sft_regs u_sft_regs (.*);
  sft_host u_sft_host (.ref_clk_i(ref_clk_i), .sda_i(sda_i), .scl_o(scl_i),
                       .sda_pull_o(host_pull));

  always #10 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    u_sft_host.wr(a, d, k);
  endtask
  task automatic r(input logic [15:0] a, input logic [7:0] e);
    u_sft_host.rd(a, q);
    chk(q, e);
  endtask
  task automatic frame;
    @(negedge ref_clk_i) frame_start_i = 1'b1;
    @(negedge ref_clk_i) frame_start_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  task automatic pix(output logic [9:0] p);
    @(negedge ref_clk_i) pixel_valid_i = 1'b1;
    @(negedge ref_clk_i) pixel_valid_i = 1'b0;
    p = pixel_o;
  endtask

  task automatic t_reset;
    r(16'h0100, 8'h20);
    r(16'h0180, 8'h06);
    chk(frame_length_o, 16'h070d);
    chk(frame_blank_o, 16'h008b);
    chk(line_blank_o, 16'h0000);
    chk(second_exposure_time_o, 16'h0004);
    chk(lanes_active_o, 16'h0004);
    $display("test reset done");
  endtask
  task automatic t_frame;
    w(16'h0340, 8'h10);
    w(16'h0341, 8'h00);
    w(16'h0202, 8'h0f);
    w(16'h0203, 8'hf0);
    w(16'h0094, 8'h05);
    chk(frame_length_o, 16'h070d);
    frame;
    chk(vertical_blank_lines_o, 16'h0ad0);
    chk(frame_length_o, 16'h1000);
    chk(line_blank_o, 16'h01f0);
    // Shutter past the frame on purpose, to reach the long-shutter path
    w(16'h0202, 8'h11);
    w(16'h0203, 8'h00);
    frame;
    chk(frame_length_o, 16'h1108);
    chk(frame_blank_o, 16'h0a86);
    chk(exposure_o, 16'h1100);
    chk(line_period_o, 16'h0780);
    w(16'h0340, 8'h11);
    w(16'h0341, 8'h08);
    frame;
    chk(vertical_blank_lines_o, 16'h0bd8);
    chk(frame_length_o, 16'h1108);
    $display("test frame done");
  endtask
  task automatic t_fields;
    logic [15:0] ad [7] = '{16'h0100, 16'h0111, 16'h0115, 16'h0222, 16'h0181, 16'h0180, 16'h008e};
    logic [7:0]  dt [7] = '{8'h0f, 8'h9a, 8'hb6, 8'hff, 8'ha5, 8'hff, 8'h0e};
    logic [7:0]  rb [7] = '{8'h0f, 8'h9a, 8'hb6, 8'h41, 8'ha5, 8'h7f, 8'h0e};
    for (int i = 0; i < 7; i++) begin
      w(ad[i], dt[i]);
      r(ad[i], rb[i]);
    end
    chk({lane_enable_o, ultra_low_power_enable_o, line_sync_mode_o, serial_out_enable_o},
        16'h000f);
    chk({virtual_channel_field_o, data_type_o}, 16'h009a);
    chk({data_lane_gate_o, all_lanes_open_o, bit_order_switch_o, clock_lane_mode_o},
        16'h0036);
    chk(timing_hold_on_divide_o, 16'h0001);
    chk({all_exposure_out_o, dual_exposure_en_o}, 16'h0003);
    chk({lane_enable_mask_o, lane_one_step_delay_o}, 16'h00a5);
    chk({serial_if_enable_o, disable_setting_o, diff_setting_o}, 16'h007f);
    chk({flip_row_offset_o, mirror_col_offset_o}, 16'h000e);
    for (int i = 0; i < 3; i++) begin
      w(16'h0114, 8'(i));
      frame;
      chk(lanes_active_o, 16'(1 << i));
    end
    $display("test fields done");
  endtask
  task automatic t_pixel;
    pix(p0);
    chk(p0, 16'h03ff);
    chk(pixel_valid_o, 16'h0001);
    w(16'h008c, 8'h14);
    pix(p0);
    pix(p1);
    chk(10'(p1 - p0), 16'h0001);
    $display("test pixel done");
  endtask
  // Commit held high stalls the queue, so the ninth byte of a burst must be refused
  task automatic t_full;
    logic [8:0] ak;
    @(negedge ref_clk_i) frame_start_i = 1'b1;
    u_sft_host.addr(16'h0120, k);
    for (int i = 0; i < 9; i++) u_sft_host.xfer(8'h11, 1'b1, q, ak[i]);
    u_sft_host.stop;
    @(negedge ref_clk_i) frame_start_i = 1'b0;
    chk(ak, 16'h00ff);
    r(16'h0127, 8'h11);
    r(16'h0128, 8'ha0);
    $display("test full done");
  endtask
  task automatic t_refuse;
    w(16'h0001, 8'h55);
    r(16'h0001, 8'h00);
    u_sft_host.start;
    u_sft_host.xfer(8'h5a, 1'b1, q, k);
    u_sft_host.stop;
    chk(k, 16'h0000);
    $display("test refuse done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    t_reset;
    t_frame;
    t_fields;
    t_pixel;
    t_full;
    t_refuse;
    close_out;
  end
  // About 35 bus transfers of roughly 600 clocks each fit well inside this span
  initial begin
    repeat (80000) @(posedge ref_clk_i);
    bad_count++;
    close_out;
  end
endmodule
